//--- rtl/phase_ctrl_defs.vh
// Register offsets, field positions and codes of the phase control block.
`ifndef PHASE_CTRL_DEFS_VH
`define PHASE_CTRL_DEFS_VH

// Register offsets.
`define A_PIN0_SEL      8'h12
`define A_PIN1_SEL      8'h13
`define A_PIN2_SEL      8'h14
`define A_PIN3_SEL      8'h15
`define A_PHASE_CTL     8'h1B
`define A_PHASE_SRC     8'h1C
`define A_MEAS_CTL      8'h1D
`define A_MEAS_A        8'h1E
`define A_MEAS_B        8'h1F

// Reset value shared by every register here.
`define REG_RST         8'h00

// Phase event control bit positions.
`define B_ABORT         7
`define B_FIRE          6
`define B_PRIME         5
`define B_FIRE_INV      1
`define B_MODE          0

// Measurement control bit positions.
`define B_MSTOP         7
`define B_MSTART        6

// Measurement input select bit positions.
`define B_EDGE_INV      7

// Status register index of the pin-state register (base 0x40 plus 1).
`define SREG_PIN_STATE  5'h01

// Prime source codes.
`define PS_ALWAYS       4'h0
`define PS_BIT          4'h1
`define PS_LOCK         4'h2

// Fire source codes.
`define FS_BIT          4'h0
`define FS_LOCK         4'h1

// Pin configuration codes for edge direction; status output is 01xx.
`define PC_RISE         4'h0
`define PC_FALL         4'h1
`define PC_STATUS       2'h1

// Phase state machine codes.
`define ST_WAIT         2'h0
`define ST_ARMED        2'h1
`define ST_ALIGN        2'h2
`define ST_APPLY        2'h3

`endif

//--- rtl/phase_adjust_measure_ctrl.v
// Phase event, pin status follow and A-to-B measurement control registers.
`timescale 1ns/1ps
`default_nettype none
`include "phase_ctrl_defs.vh"

module phase_adjust_measure_ctrl (
    input  wire         i_core_clk,
    input  wire         i_sys_rst,
    input  wire         i_reg_wr,
    input  wire         i_reg_rd,
    input  wire [7:0]   i_reg_addr,
    input  wire [7:0]   i_reg_wdata,
    output reg  [7:0]   o_reg_rdata,
    input  wire [255:0] i_status_bits,
    input  wire [255:0] i_status_impl,
    input  wire [15:0]  i_pin_config,
    input  wire [3:0]   i_pin_level,
    input  wire         i_apll_locked,
    input  wire [2:0]   i_input_clk,
    input  wire [2:0]   i_output_clk,
    output reg  [3:0]   o_pin_status,
    output wire         o_phase_armed,
    output wire         o_div_reset,
    output wire         o_offset_apply,
    output wire         o_phase_mode_adjust,
    output wire         o_meas_start,
    output wire         o_meas_stop,
    output reg          o_meas_running,
    output wire [2:0]   o_time_base_select,
    output wire         o_time_base_bad,
    output reg          o_meas_a,
    output reg          o_meas_b
);

    // Stored register fields.
    reg [7:0] pin_sel [0:3];
    reg       abort_cmd;
    reg       fire_bit;
    reg       prime_cmd;
    reg       fire_polarity_flip;
    reg       phase_mode;
    reg [3:0] prime_source_sel;
    reg [3:0] fire_source_sel;
    reg       mstop_cmd;
    reg       mstart_cmd;
    reg [2:0] time_base_select;
    reg       input_a_edge_flip;
    reg [4:0] input_a_select;
    reg       input_b_edge_flip;
    reg [4:0] input_b_select;

    // Phase state and edge history.
    reg [1:0] state;
    reg [1:0] next_state;
    reg [3:0] pin_prev;
    reg       lock_prev;
    reg       arm_hit;
    reg       fire_bit_hit;
    integer   k;
    // The status follow loop has its own index, so that each loop
    // variable is written by one process only.
    integer   j;

    // Per-register write strobes.
    wire wr_pc = i_reg_wr && (i_reg_addr == `A_PHASE_CTL);
    wire wr_ps = i_reg_wr && (i_reg_addr == `A_PHASE_SRC);
    wire wr_mc = i_reg_wr && (i_reg_addr == `A_MEAS_CTL);
    wire wr_ma = i_reg_wr && (i_reg_addr == `A_MEAS_A);
    wire wr_mb = i_reg_wr && (i_reg_addr == `A_MEAS_B);

    // Lock edges; for the trigger source the flip swaps which direction counts.
    wire lock_up = i_apll_locked && !lock_prev;
    wire lock_dn = !i_apll_locked && lock_prev;

    // Edge of pin n in the direction its config asks for, optionally
    // reversed by the trigger flip. Other configs never give an edge.
    function pin_edge;
        input [1:0]  n;
        input        inv;
        input [15:0] cfg;
        input [3:0]  now;
        input [3:0]  old;
        reg   [3:0]  c;
        reg          up;
        reg          dn;
        begin
            c  = cfg[n*4 +: 4];
            up = now[n] && !old[n];
            dn = !now[n] && old[n];
            if (c == `PC_RISE) begin
                pin_edge = inv ? dn : up;
            end else if (c == `PC_FALL) begin
                pin_edge = inv ? up : dn;
            end else begin
                pin_edge = 1'b0;
            end
        end
    endfunction

    // Measurement input source mux; unlisted codes give a quiet zero.
    function src_pick;
        input [4:0] sel;
        input [2:0] ic;
        input [3:0] pin;
        input [2:0] oc;
        begin
            case (sel)
                5'h00: src_pick = ic[0];
                5'h01: src_pick = ic[1];
                5'h02: src_pick = ic[2];
                5'h08: src_pick = pin[0];
                5'h09: src_pick = pin[1];
                5'h0A: src_pick = pin[2];
                5'h0B: src_pick = pin[3];
                5'h10: src_pick = oc[0];
                5'h11: src_pick = oc[1];
                5'h12: src_pick = oc[2];
                default: src_pick = 1'b0;
            endcase
        end
    endfunction

    // Register writes. Reserved bits are never stored, so they read zero.
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            for (k = 0; k < 4; k = k + 1) begin
                pin_sel[k] <= `REG_RST;
            end
            fire_polarity_flip <= 1'b0;
            phase_mode         <= 1'b0;
            prime_source_sel   <= 4'h0;
            fire_source_sel    <= 4'h0;
            time_base_select   <= 3'h0;
            input_a_edge_flip  <= 1'b0;
            input_a_select     <= 5'h00;
            input_b_edge_flip  <= 1'b0;
            input_b_select     <= 5'h00;
        end else begin
            for (k = 0; k < 4; k = k + 1) begin
                if (i_reg_wr && (i_reg_addr == `A_PIN0_SEL + k[7:0])) begin
                    pin_sel[k] <= i_reg_wdata;
                end
            end
            if (wr_pc) begin
                fire_polarity_flip <= i_reg_wdata[`B_FIRE_INV];
                phase_mode         <= i_reg_wdata[`B_MODE];
            end
            if (wr_ps) begin
                prime_source_sel <= i_reg_wdata[7:4];
                fire_source_sel  <= i_reg_wdata[3:0];
            end
            if (wr_mc) begin
                time_base_select <= i_reg_wdata[2:0];
            end
            if (wr_ma) begin
                input_a_edge_flip <= i_reg_wdata[`B_EDGE_INV];
                input_a_select    <= i_reg_wdata[4:0];
            end
            if (wr_mb) begin
                input_b_edge_flip <= i_reg_wdata[`B_EDGE_INV];
                input_b_select    <= i_reg_wdata[4:0];
            end
        end
    end

    // Command bits live for the single cycle after their write, which is
    // the cycle the logic acts on them, and then clear themselves.
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            abort_cmd  <= 1'b0;
            fire_bit   <= 1'b0;
            prime_cmd  <= 1'b0;
            mstop_cmd  <= 1'b0;
            mstart_cmd <= 1'b0;
        end else begin
            abort_cmd  <= wr_pc && i_reg_wdata[`B_ABORT];
            // A write of 0 clears the fire bit at once as well.
            fire_bit   <= wr_pc && i_reg_wdata[`B_FIRE];
            prime_cmd  <= wr_pc && i_reg_wdata[`B_PRIME];
            mstop_cmd  <= wr_mc && i_reg_wdata[`B_MSTOP];
            mstart_cmd <= wr_mc && i_reg_wdata[`B_MSTART];
        end
    end

    // Edge history for lock and pin transitions.
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            // Follow the inputs in reset too, so that a pin or a lock that
            // is already high at release is not taken as a rising edge.
            pin_prev  <= i_pin_level;
            lock_prev <= i_apll_locked;
        end else begin
            pin_prev  <= i_pin_level;
            lock_prev <= i_apll_locked;
        end
    end

    // Arming source select. Unused codes never arm.
    always @* begin
        arm_hit = 1'b0;
        case (prime_source_sel)
            `PS_ALWAYS: arm_hit = 1'b1;
            `PS_BIT:    arm_hit = prime_cmd;
            `PS_LOCK:   arm_hit = lock_up;
            4'h8, 4'h9, 4'hA, 4'hB: begin
                arm_hit = pin_edge(prime_source_sel[1:0], 1'b0,
                                   i_pin_config, i_pin_level, pin_prev);
            end
            default:    arm_hit = 1'b0;
        endcase
    end

    // Trigger source select; hardware sources honour the polarity flip.
    always @* begin
        fire_bit_hit = 1'b0;
        case (fire_source_sel)
            `FS_BIT:  fire_bit_hit = fire_bit;
            `FS_LOCK: fire_bit_hit = fire_polarity_flip ? lock_dn : lock_up;
            4'h8, 4'h9, 4'hA, 4'hB: begin
                fire_bit_hit = pin_edge(fire_source_sel[1:0], fire_polarity_flip,
                                    i_pin_config, i_pin_level, pin_prev);
            end
            default:  fire_bit_hit = 1'b0;
        endcase
    end

    // Phase state machine. Abort only takes back an armed, untriggered
    // event; an event already under way runs to its end.
    always @* begin
        next_state = state;
        case (state)
            `ST_WAIT: begin
                // An always-armed source rearms one cycle after an event
                // or an abort; a same-cycle abort keeps the machine here.
                if (!abort_cmd && arm_hit) begin
                    next_state = `ST_ARMED;
                end
            end
            `ST_ARMED: begin
                if (abort_cmd) begin
                    next_state = `ST_WAIT;
                end else if (fire_bit_hit) begin
                    // Alignment resets dividers first; adjustment does not.
                    next_state = phase_mode ? `ST_APPLY : `ST_ALIGN;
                end
            end
            `ST_ALIGN: next_state = `ST_APPLY;
            `ST_APPLY: next_state = `ST_WAIT;
            default:   next_state = `ST_WAIT;
        endcase
    end

    // State register; triggers outside the armed state fall through.
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state <= `ST_WAIT;
        end else begin
            state <= next_state;
        end
    end

    // Phase event outputs decode the registered state; the mode output is the stored mode bit.
    assign o_phase_armed       = (state == `ST_ARMED);
    assign o_div_reset         = (state == `ST_ALIGN);
    assign o_offset_apply      = (state == `ST_APPLY);
    assign o_phase_mode_adjust = phase_mode;

    // Measurement control. Stop wins if both arrive together, so a
    // combined write leaves the measurement halted.
    assign o_meas_start       = mstart_cmd;
    assign o_meas_stop        = mstop_cmd;
    assign o_time_base_select = time_base_select;
    // Code 000 is stored as written and only flagged, so that software
    // can read back what it wrote; the time base logic must not use it.
    assign o_time_base_bad    = (time_base_select == 3'h0) ||
                                (time_base_select > 3'h3);

    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_meas_running <= 1'b0;
        end else if (mstop_cmd) begin
            o_meas_running <= 1'b0;
        end else if (mstart_cmd) begin
            o_meas_running <= 1'b1;
        end
    end

    // Measurement inputs, inverted for falling-edge measurement.
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_meas_a <= 1'b0;
            o_meas_b <= 1'b0;
        end else begin
            o_meas_a <= src_pick(input_a_select, i_input_clk, i_pin_level,
                                 i_output_clk) ^ input_a_edge_flip;
            o_meas_b <= src_pick(input_b_select, i_input_clk, i_pin_level,
                                 i_output_clk) ^ input_b_edge_flip;
        end
    end

    // Status follow. The 8-bit index {register, bit} addresses the flat
    // status vector whose bit 0 is bit 0 of the register at 0x40.
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_pin_status <= 4'h0;
        end else begin
            // The pin-state bits are blocked by index: a pin that followed
            // its own level would form a loop through the pin driver.
            for (j = 0; j < 4; j = j + 1) begin
                o_pin_status[j] <=
                    (i_pin_config[j*4+2 +: 2] == `PC_STATUS) &&
                    (pin_sel[j][7:3] != `SREG_PIN_STATE) &&
                    i_status_impl[pin_sel[j]] &&
                    i_status_bits[pin_sel[j]];
            end
        end
    end

    // Read port. Data is registered on the read strobe; unmapped
    // addresses and reserved bits return zero.
    always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `A_PIN0_SEL:  o_reg_rdata <= pin_sel[0];
                `A_PIN1_SEL:  o_reg_rdata <= pin_sel[1];
                `A_PIN2_SEL:  o_reg_rdata <= pin_sel[2];
                `A_PIN3_SEL:  o_reg_rdata <= pin_sel[3];
                `A_PHASE_CTL: o_reg_rdata <= {abort_cmd, fire_bit, prime_cmd,
                                              3'h0, fire_polarity_flip,
                                              phase_mode};
                `A_PHASE_SRC: o_reg_rdata <= {prime_source_sel,
                                              fire_source_sel};
                `A_MEAS_CTL:  o_reg_rdata <= {mstop_cmd, mstart_cmd, 3'h0,
                                              time_base_select};
                `A_MEAS_A:    o_reg_rdata <= {input_a_edge_flip, 2'h0,
                                              input_a_select};
                `A_MEAS_B:    o_reg_rdata <= {input_b_edge_flip, 2'h0,
                                              input_b_select};
                default:      o_reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule // phase_adjust_measure_ctrl
`default_nettype wire

//--- test/phase_ctrl_checker.sv
// Port-level assertions of the phase control block.
`timescale 1ns/1ps
`default_nettype none
`include "phase_ctrl_defs.vh"
module phase_ctrl_checker (
    input wire logic        i_core_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  i_reg_addr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic [15:0] i_pin_config,
    input wire logic [3:0]  o_pin_status,
    input wire logic        o_phase_armed,
    input wire logic        o_div_reset,
    input wire logic        o_offset_apply,
    input wire logic        o_phase_mode_adjust,
    input wire logic        o_meas_start,
    input wire logic        o_meas_stop,
    input wire logic        o_meas_running,
    input wire logic [2:0]  o_time_base_select,
    input wire logic        o_time_base_bad
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    // Decoded register strobes shared by the properties.
    wire ctl_rd = i_reg_rd && i_reg_addr == `A_PHASE_CTL;
    wire m_wr   = i_reg_wr && i_reg_addr == `A_MEAS_CTL;

    a_align_order: assert property (
        o_div_reset |=> o_offset_apply && !o_div_reset)
        else $error("offset apply did not follow divider reset");
    a_adjust_no_reset: assert property (
        o_div_reset |-> !o_phase_mode_adjust)
        else $error("divider reset in adjustment mode");
    a_apply_cause: assert property (
        $rose(o_offset_apply) |-> $past(o_div_reset) || $past(o_phase_armed))
        else $error("offset apply without armed event");
    a_event_disarms: assert property (
        o_div_reset || o_offset_apply |-> !o_phase_armed)
        else $error("armed during event");
    a_start_cmd: assert property (
        m_wr && i_reg_wdata[6] && !i_reg_wdata[7] |-> ##[1:2] o_meas_start)
        else $error("start pulse missing");
    a_start_pulse: assert property (
        o_meas_start |=> !o_meas_start)
        else $error("start pulse too long");
    a_stop_cmd: assert property (
        m_wr && i_reg_wdata[7] |-> ##[1:2] o_meas_stop ##1 !o_meas_running)
        else $error("stop did not halt measurement");
    a_time_base_flag: assert property (
        o_time_base_bad == (o_time_base_select == 3'h0 ||
                            o_time_base_select > 3'h3))
        else $error("time base flag wrong");
    a_status_gate: assert property (
        i_pin_config[3:2] != 2'h1 |=> !o_pin_status[0])
        else $error("pin follows status while not a status output");
    a_unmapped_read: assert property (
        i_reg_rd && i_reg_addr > 8'h1F |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reserved_read: assert property (
        ctl_rd |=> o_reg_rdata[4:2] == 3'h0)
        else $error("reserved bits not zero");
    a_cmd_clear: assert property (
        ctl_rd && !$past(i_reg_wr) |=> o_reg_rdata[7:5] == 3'h0)
        else $error("command bits still set");

    // Main scenarios reached by the bench.
    c_align: cover property (o_div_reset);
    c_adjust: cover property (o_offset_apply && o_phase_mode_adjust);
    c_start: cover property (o_meas_start);
    c_stop: cover property (o_meas_stop);
endmodule // phase_ctrl_checker

bind phase_adjust_measure_ctrl phase_ctrl_checker u_phase_ctrl_checker (.*);
`default_nettype wire

//--- test/phase_adjust_measure_ctrl_tb_top.sv
// Self-checking testbench of the phase control block.
`timescale 1ns/1ps
`default_nettype none
`include "phase_ctrl_defs.vh"
module phase_adjust_measure_ctrl_tb_top;
    logic         i_core_clk = 1'b0;
    logic         i_sys_rst = 1'b1;
    logic         i_reg_wr = 1'b0;
    logic         i_reg_rd = 1'b0;
    logic         i_apll_locked = 1'b0;
    logic [7:0]   i_reg_addr = 8'h00;
    logic [7:0]   i_reg_wdata = 8'h00;
    logic [255:0] i_status_bits = '0;
    logic [255:0] i_status_impl = '0;
    logic [15:0]  i_pin_config = 16'h0000;
    logic [3:0]   i_pin_level = 4'h0;
    logic [2:0]   i_input_clk = 3'h0;
    logic [2:0]   i_output_clk = 3'h0;
    wire  [7:0]   o_reg_rdata;
    wire  [3:0]   o_pin_status;
    wire  [2:0]   o_time_base_select;
    wire          o_phase_armed, o_div_reset, o_offset_apply;
    wire          o_phase_mode_adjust, o_meas_start, o_meas_stop;
    wire          o_meas_running, o_time_base_bad, o_meas_a, o_meas_b;
    int           mismatches = 0;
    int           comparisons = 0;
    logic [7:0]   d;

    phase_adjust_measure_ctrl u_phase_adjust_measure_ctrl (.*);

    // Free-running 100 MHz clock.
    always #5 i_core_clk = ~i_core_clk;

    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask

    // Strobes rise and fall on different falling edges, so calls chain safely.
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge i_core_clk);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = v;
        @(negedge i_core_clk);
        i_reg_wr = 1'b0;
    endtask

    task rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge i_core_clk);
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        @(negedge i_core_clk);
        i_reg_rd = 1'b0;
        v = o_reg_rdata;
    endtask

    // Watches one pulse output for six cycles: 0 event, 1 start, 2 stop.
    task ev(input int w, input logic e);
        logic [2:0] s;
        logic       seen;
        seen = 1'b0;
        // Look before waiting: a command pulse stands only in the cycle
        // right after its write, which is when the caller arrives here.
        repeat (6) begin
            s = {o_meas_stop, o_meas_start, o_div_reset | o_offset_apply};
            seen = seen | s[w];
            @(negedge i_core_clk);
        end
        chk("pulse", e, seen);
    endtask

    task t_regs;
        logic [7:0] ra [10] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h1B,
                                8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20};
        logic [7:0] wm [10] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h03,
                                8'hFF, 8'h07, 8'h9F, 8'h9F, 8'h00};
        cyc(2);
        chk("armed", 1, o_phase_armed);
        for (int i = 0; i < 10; i++) begin
            rd(ra[i], d);
            chk("reset", 8'h00, d);
            wr(ra[i], 8'hFF);
            rd(ra[i], d);
            chk("readback", wm[i], d);
            wr(ra[i], 8'h00);
        end
        wr(`A_PHASE_CTL, 8'h80);
    endtask

    task t_fire;
        logic [5:0] got;
        for (int m = 0; m < 2; m++) begin
            wr(`A_PHASE_CTL, m ? 8'h41 : 8'h40);
            got = 6'h00;
            repeat (3) begin
                got = {got[3:0], o_div_reset, o_offset_apply};
                @(negedge i_core_clk);
            end
            chk("event", m ? 8'h04 : 8'h09, {2'h0, got});
            chk("mode", m, o_phase_mode_adjust);
        end
        rd(`A_PHASE_CTL, d);
        chk("ctl", 8'h01, d);
        wr(`A_PHASE_CTL, 8'h00);
    endtask

    task t_prime;
        wr(`A_PHASE_SRC, 8'h10);
        wr(`A_PHASE_CTL, 8'h80);
        cyc(2);
        chk("armed", 0, o_phase_armed);
        wr(`A_PHASE_CTL, 8'h40);
        ev(0, 0);
        wr(`A_PHASE_CTL, 8'hA0);
        cyc(2);
        chk("armed", 0, o_phase_armed);
        wr(`A_PHASE_CTL, 8'h20);
        cyc(2);
        chk("armed", 1, o_phase_armed);
        wr(`A_PHASE_CTL, 8'h00);
        cyc(2);
        chk("armed", 1, o_phase_armed);
        wr(`A_PHASE_CTL, 8'h40);
        ev(0, 1);
        chk("armed", 0, o_phase_armed);
        wr(`A_PHASE_CTL, 8'h60);
        cyc(2);
        chk("armed", 1, o_phase_armed);
        wr(`A_PHASE_CTL, 8'h80);
    endtask

    task t_pins;
        // Each trigger edge waits one cycle after the prime write, so that it
        // lands while the machine is already armed.
        wr(`A_PHASE_SRC, 8'h18);
        wr(`A_PHASE_CTL, 8'h20);
        cyc(1);
        i_pin_level = 4'h1;
        ev(0, 1);
        i_pin_config = 16'h0001;
        wr(`A_PHASE_CTL, 8'h20);
        cyc(1);
        i_pin_level = 4'h0;
        ev(0, 1);
        wr(`A_PHASE_CTL, 8'h20);
        cyc(1);
        i_pin_level = 4'h1;
        ev(0, 0);
        i_pin_config = 16'h0000;
        wr(`A_PHASE_CTL, 8'h80);
        wr(`A_PHASE_CTL, 8'h22);
        cyc(1);
        i_pin_level = 4'h0;
        ev(0, 1);
        wr(`A_PHASE_SRC, 8'h11);
        wr(`A_PHASE_CTL, 8'h20);
        cyc(1);
        i_apll_locked = 1'b1;
        ev(0, 1);
        wr(`A_PHASE_SRC, 8'h20);
        i_apll_locked = 1'b0;
        cyc(3);
        chk("armed", 0, o_phase_armed);
        i_apll_locked = 1'b1;
        cyc(3);
        chk("armed", 1, o_phase_armed);
        wr(`A_PHASE_SRC, 8'h00);
        wr(`A_PHASE_CTL, 8'h80);
    endtask

    task t_meas;
        logic [4:0] sc [10] = '{5'h00, 5'h01, 5'h02, 5'h08, 5'h09,
                                5'h0A, 5'h0B, 5'h10, 5'h11, 5'h12};
        logic [9:0] v;
        wr(`A_MEAS_CTL, 8'h41);
        ev(1, 1);
        chk("running", 1, o_meas_running);
        wr(`A_MEAS_CTL, 8'h81);
        ev(2, 1);
        chk("running", 0, o_meas_running);
        for (int t = 0; t < 4; t++) begin
            wr(`A_MEAS_CTL, t[7:0]);
            chk("tb bad", t == 0, o_time_base_bad);
            chk("tb sel", t[7:0], {5'h00, o_time_base_select});
        end
        i_input_clk = 3'h5;
        i_pin_level = 4'h6;
        i_output_clk = 3'h2;
        v = {i_output_clk, i_pin_level, i_input_clk};
        for (int k = 0; k < 10; k++) begin
            wr(`A_MEAS_A, {3'h0, sc[k]});
            wr(`A_MEAS_B, {3'h4, sc[k]});
            cyc(2);
            chk("meas a", v[k], o_meas_a);
            chk("meas b", !v[k], o_meas_b);
        end
    endtask

    task t_follow;
        logic [7:0] pat;
        pat = 8'hA5;
        i_status_impl = ~256'h0;
        i_status_impl[18] = 1'b0;
        i_status_bits = ~256'h0;
        i_status_bits[23:16] = pat;
        i_pin_config = 16'h4040;
        for (int b = 0; b < 8; b++) begin
            wr(`A_PIN1_SEL, {5'h02, b[2:0]});
            cyc(2);
            chk("pin1", pat[b] && b != 2, o_pin_status[1]);
        end
        wr(`A_PIN3_SEL, {`SREG_PIN_STATE, 3'h3});
        cyc(2);
        chk("pin3", 0, o_pin_status[3]);
        i_pin_config = 16'h4444;
        wr(`A_PIN0_SEL, {5'h02, 3'h0});
        wr(`A_PIN2_SEL, {5'h02, 3'h7});
        cyc(2);
        chk("pin0", 1, o_pin_status[0]);
        chk("pin2", 1, o_pin_status[2]);
        chk("pin1", 1, o_pin_status[1]);
        i_pin_config = 16'h0000;
        cyc(2);
        chk("pin1", 0, o_pin_status[1]);
        chk("pin0", 0, o_pin_status[0]);
    endtask

    task results;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Main sequence after a 12-cycle reset.
    initial begin
        repeat (12) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        t_regs;
        t_fire;
        t_prime;
        t_pins;
        t_meas;
        t_follow;
        results;
    end

    // Watchdog well beyond the roughly 340 cycles the tests take.
    initial begin
        #100000;
        mismatches++;
        results;
    end
endmodule // phase_adjust_measure_ctrl_tb_top
`default_nettype wire
